// ---- rtl/acc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module acc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register access from the serial decoder
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [1:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Global setup
    input wire logic scan_enable,
    input wire logic pairing_select,
    input wire logic [1:0] calibration_mode_select,
    input wire logic [1:0] channel_select_code,
    input wire logic conv_step,
    // Modulator and filter
    input wire logic mod_strobe,
    input wire logic mod_bit,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [acc_pkg::RESULT_W-1:0] result_data,
    output logic mod_filter_reset,
    output logic filter_run,
    output logic osc_enable,
    output logic full_power_down,
    // Active channel settings
    output logic [acc_pkg::TF_GAIN_W-1:0] pga_gain_code,
    output logic [7:0] pga_gain_factor,
    output logic unipolar,
    output logic offset_dac_sign,
    output logic [acc_pkg::TF_DAC_MAG_W-1:0] offset_dac_mag,
    output logic offset_dac_connect,
    output logic [1:0] active_tf,
    output logic [2:0] active_tag,
    output logic [2:0] active_input,
    output logic active_is_cal,
    output logic active_cal_gain,
    output logic common_input_ref,
    // Serial pins
    input wire logic read_req,
    input wire logic read_special,
    input wire logic sclk,
    output logic dout,
    output logic drdy_n,
    output logic bitstream_output_select
);
    localparam int SW = $clog2(acc_pkg::SETTLE_CYCLES + 1);
    localparam int TW = $clog2(acc_pkg::STROBE_HIGH_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE = SW'(acc_pkg::SETTLE_CYCLES);
    localparam logic [TW-1:0] STROBE = TW'(acc_pkg::STROBE_HIGH_CYCLES);
    localparam logic [4:0] SER_LEN = 5'(acc_pkg::SER_BITS);
    localparam int MSB = acc_pkg::SER_BITS - 1;

    acc_route_if rt ();

    logic stream_sel, next_stream_sel, full_pd, next_full_pd;
    logic [7:0] tf_reg [acc_pkg::TF_COUNT];
    logic [7:0] next_tf [acc_pkg::TF_COUNT];
    logic [7:0] next_rdata, act;
    logic [5:0] glob_q, glob_now;
    logic [1:0] wr_idx, act_idx;
    logic active_change;
    logic [SW-1:0] settle_cnt, next_settle;
    logic [TW-1:0] strb_cnt, next_strb;
    logic bit_q, next_bit, next_drdy_n, next_filter_reset;
    logic s1, s2, s3, sclk_lvl, next_sclk_lvl, sclk_fall;
    acc_pkg::acc_ser_e ser_state, next_ser_state;
    logic [MSB:0] shreg, next_shreg;
    logic [4:0] bitcnt, next_bitcnt;
    logic rd_data, next_rd_data, fifo_pop, accept_ok, buf_in_ready, buf_valid;
    logic [acc_pkg::RESULT_W-1:0] buf_data;

    assign rt.scan = scan_enable;
    assign rt.pairing = pairing_select;
    assign rt.cal_mode = calibration_mode_select;
    assign rt.chsel = channel_select_code;
    assign rt.step = conv_step && !full_pd;

    acc_route u_route (
        .clk(clk),
        .sys_rst(sys_rst),
        .rt(rt)
    );

    // Results arriving while the filter settles or sleeps are dropped
    assign accept_ok = (settle_cnt == '0) && !full_pd;
    assign result_ready = buf_in_ready && accept_ok;

    acc_fifo #(
        .W(acc_pkg::RESULT_W),
        .DEPTH(acc_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(result_valid && accept_ok),
        .in_ready(buf_in_ready),
        .in_data(result_data),
        .out_valid(buf_valid),
        .out_ready(fifo_pop),
        .out_data(buf_data)
    );

    // Configuration registers and active-channel decode
    always_comb
    begin
        glob_now = {scan_enable, pairing_select, calibration_mode_select, channel_select_code};
        wr_idx = cfg_addr - 2'h1;
        act_idx = rt.tf_sel - 2'h1;
        act = tf_reg[act_idx];
        next_stream_sel = stream_sel;
        next_full_pd = full_pd;
        next_tf = tf_reg;
        next_rdata = cfg_rdata;
        if (cfg_wr && cfg_addr == acc_pkg::ADDR_SPECIAL)
        begin
            // Only the two defined bits are kept, the power-down bit only ever being set; the rest stay zero
            next_stream_sel = cfg_wdata[acc_pkg::SPECIAL_STREAM_BIT];
            next_full_pd = full_pd | cfg_wdata[acc_pkg::SPECIAL_PD_BIT];
        end
        else if (cfg_wr)
        begin
            next_tf[wr_idx] = cfg_wdata;
        end
        if (cfg_rd)
        begin
            next_rdata = (cfg_addr == acc_pkg::ADDR_SPECIAL) ? 8'h00 : tf_reg[wr_idx];
        end
        active_change = (cfg_wr && cfg_addr != acc_pkg::ADDR_SPECIAL && wr_idx == act_idx
                         && cfg_wdata != act) || (glob_now != glob_q);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stream_sel <= acc_pkg::SPECIAL_RST[acc_pkg::SPECIAL_STREAM_BIT];
            full_pd <= acc_pkg::SPECIAL_RST[acc_pkg::SPECIAL_PD_BIT];
            for (int i = 0; i < acc_pkg::TF_COUNT; i++)
            begin
                tf_reg[i] <= acc_pkg::TF_RST;
            end
            cfg_rdata <= 8'h00;
            glob_q <= 6'h00;
            pga_gain_code <= '0;
            pga_gain_factor <= 8'h01;
            unipolar <= 1'b0;
            offset_dac_sign <= 1'b0;
            offset_dac_mag <= '0;
            offset_dac_connect <= 1'b0;
        end
        else
        begin
            stream_sel <= next_stream_sel;
            full_pd <= next_full_pd;
            tf_reg <= next_tf;
            cfg_rdata <= next_rdata;
            glob_q <= glob_now;
            pga_gain_code <= act[acc_pkg::TF_GAIN_LSB +: acc_pkg::TF_GAIN_W];
            pga_gain_factor <= 8'h01 << act[acc_pkg::TF_GAIN_LSB +: acc_pkg::TF_GAIN_W];
            // Polarity drives unipolar; like any active-register change, flipping it also resets the filter
            unipolar <= act[acc_pkg::TF_POL_BIT];
            offset_dac_sign <= act[acc_pkg::TF_DAC_SIGN_BIT];
            offset_dac_mag <= act[acc_pkg::TF_DAC_MAG_W-1:0];
            offset_dac_connect <= (act[acc_pkg::TF_DAC_MAG_W-1:0] != '0);
        end
    end

    assign full_power_down = full_pd;
    assign osc_enable = !full_pd;
    assign filter_run = !full_pd;
    assign bitstream_output_select = stream_sel;
    assign active_tf = rt.tf_sel;
    assign active_tag = rt.tag;
    assign active_input = rt.pos_input;
    assign active_is_cal = rt.is_cal;
    assign active_cal_gain = rt.cal_gain;
    assign common_input_ref = !pairing_select;

    // Settling, modulator strobe and ready pin
    always_comb
    begin
        next_settle = settle_cnt;
        if (active_change)
        begin
            next_settle = SETTLE;
        end
        else if (settle_cnt != '0)
        begin
            next_settle = settle_cnt - 1'b1;
        end
        next_strb = strb_cnt;
        next_bit = bit_q;
        if (stream_sel && mod_strobe)
        begin
            next_strb = STROBE;
            next_bit = mod_bit;
        end
        else if (strb_cnt != '0)
        begin
            next_strb = strb_cnt - 1'b1;
        end
        next_filter_reset = active_change;
        next_drdy_n = stream_sel ? (next_strb != '0)
                                 : (!buf_valid || next_settle != '0 || active_change);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            settle_cnt <= '0;
            strb_cnt <= '0;
            bit_q <= 1'b0;
            mod_filter_reset <= 1'b0;
            drdy_n <= 1'b1;
        end
        else
        begin
            settle_cnt <= next_settle;
            strb_cnt <= next_strb;
            bit_q <= next_bit;
            mod_filter_reset <= next_filter_reset;
            drdy_n <= next_drdy_n;
        end
    end

    // Serial shifter; only the agreeing second and third sync stages are read
    assign sclk_fall = sclk_lvl && !s2 && !s3;

    always_comb
    begin
        next_sclk_lvl = (s2 == s3) ? s3 : sclk_lvl;
        next_ser_state = ser_state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_rd_data = rd_data;
        fifo_pop = 1'b0;
        case (ser_state)
            acc_pkg::ACC_SER_IDLE:
            begin
                if (read_req)
                begin
                    next_ser_state = acc_pkg::ACC_SER_SHIFT;
                    next_bitcnt = SER_LEN;
                    next_rd_data = !read_special && buf_valid;
                    next_shreg = (!read_special && buf_valid) ? buf_data : '0;
                end
            end
            acc_pkg::ACC_SER_SHIFT:
            begin
                if (sclk_fall)
                begin
                    next_shreg = {shreg[MSB-1:0], 1'b0};
                    next_bitcnt = bitcnt - 5'h01;
                    if (bitcnt == 5'h01)
                    begin
                        next_ser_state = acc_pkg::ACC_SER_IDLE;
                        fifo_pop = rd_data;
                    end
                end
            end
            default:
            begin
                next_ser_state = acc_pkg::ACC_SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sclk_lvl <= 1'b0;
            ser_state <= acc_pkg::ACC_SER_IDLE;
            shreg <= '0;
            bitcnt <= 5'h00;
            rd_data <= 1'b0;
        end
        else
        begin
            s1 <= sclk;
            s2 <= s1;
            s3 <= s2;
            sclk_lvl <= next_sclk_lvl;
            ser_state <= next_ser_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            rd_data <= next_rd_data;
        end
    end

    assign dout = stream_sel ? bit_q : shreg[MSB];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    normal_dout_a:
    assert property (!stream_sel && ser_state == acc_pkg::ACC_SER_SHIFT && sclk_fall ##1 !stream_sel
                     |-> dout == $past(shreg[MSB-1]))
        else $error("serial output did not advance one bit");
    stream_bit_a:
    assert property (stream_sel && mod_strobe ##1 stream_sel |-> dout == $past(mod_bit))
        else $error("modulator bit not presented");
    stream_strobe_a:
    assert property (stream_sel && mod_strobe ##1 (stream_sel && !mod_strobe) [*2]
                     |-> drdy_n ##1 !drdy_n)
        else $error("strobe did not fall after high phase");
    filter_alive_a:
    assert property (stream_sel && result_valid && result_ready |=> buf_valid)
        else $error("result lost during bitstream output");
    read_back_a:
    assert property (ser_state == acc_pkg::ACC_SER_IDLE && read_req && !read_special && buf_valid
                     |=> shreg == $past(buf_data) && bitcnt == SER_LEN)
        else $error("held result not loaded for read");
    power_down_a:
    assert property (full_pd |=> full_pd && !osc_enable && !filter_run)
        else $error("power-down left before reset");
    special_read_a:
    assert property (ser_state == acc_pkg::ACC_SER_IDLE && read_req && read_special
                     |=> shreg == '0 && bitcnt == SER_LEN)
        else $error("mistaken read not a 24-bit zero word");
    change_reset_a:
    assert property (active_change && !stream_sel |=> drdy_n && mod_filter_reset && settle_cnt == SETTLE)
        else $error("active change did not reset filter");
    quiet_write_a:
    assert property (cfg_wr && cfg_addr != acc_pkg::ADDR_SPECIAL && cfg_addr - 2'h1 != rt.tf_sel - 2'h1
                     && $stable(glob_now) && settle_cnt == '0 |=> !mod_filter_reset)
        else $error("inactive write reset the filter");
    gain_decode_a:
    assert property (##1 pga_gain_factor == 8'h01 << $past(act[acc_pkg::TF_GAIN_LSB +: acc_pkg::TF_GAIN_W]))
        else $error("gain factor not a power of two of code");
    held_result_a:
    assert property (cfg_wr && cfg_addr != acc_pkg::ADDR_SPECIAL && buf_valid && !fifo_pop
                     |=> buf_data == $past(buf_data))
        else $error("held result changed by setting write");
    dac_open_a:
    assert property (##1 offset_dac_connect == ($past(act[acc_pkg::TF_DAC_MAG_W-1:0]) != '0))
        else $error("zero offset code left DAC connected");
    special_bits_a:
    assert property (cfg_wr && cfg_addr == acc_pkg::ADDR_SPECIAL
                     |=> stream_sel == $past(cfg_wdata[acc_pkg::SPECIAL_STREAM_BIT]))
        else $error("stream select not at bit five");
endmodule
`default_nettype wire

// ---- shared/acc_pkg.sv ----
`default_nettype none
package acc_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 4000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_NS = 20;
    localparam int STROBE_HIGH_CYCLES = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Serial word and result
    localparam int SER_BITS = 24;
    localparam int RESULT_W = 24;
    localparam int BUF_DEPTH = 2;
    // Register selection
    localparam logic [1:0] ADDR_SPECIAL = 2'h0;
    localparam int TF_COUNT = 3;
    localparam logic [1:0] TF_LAST = 2'h3;
    // Special-mode register fields
    localparam int SPECIAL_STREAM_BIT = 5;
    localparam int SPECIAL_PD_BIT = 0;
    localparam logic [7:0] SPECIAL_RST = 8'h00;
    // Transfer-function register fields
    localparam int TF_GAIN_LSB = 5;
    localparam int TF_GAIN_W = 3;
    localparam int TF_POL_BIT = 4;
    localparam int TF_DAC_SIGN_BIT = 3;
    localparam int TF_DAC_MAG_W = 3;
    localparam logic [7:0] TF_RST = 8'h00;
    // Calibration modes and channels
    localparam logic [1:0] CAL_NONE = 2'h0;
    localparam logic [1:0] CAL_OFFSET = 2'h1;
    localparam logic [1:0] CAL_GAIN = 2'h2;
    localparam int PSEUDO_INPUTS = 5;
    localparam int PAIRING_SELECT_PAIRS = 3;
    // Tag shared by both calibration channels; value arbitrary
    localparam logic [2:0] CAL_TAG = 3'h5;

    typedef enum logic [1:0] {
        ACC_SER_IDLE = 2'b01,
        ACC_SER_SHIFT = 2'b10
    } acc_ser_e;
endpackage
`default_nettype wire

// ---- shared/acc_route_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface acc_route_if;
    logic scan;
    logic pairing;
    logic [1:0] cal_mode;
    logic [1:0] chsel;
    logic step;
    logic [1:0] tf_sel;
    logic [2:0] pos_input;
    logic [2:0] tag;
    logic is_cal;
    logic cal_gain;
    modport route (input scan, pairing, cal_mode, chsel, step,
                   output tf_sel, pos_input, tag, is_cal, cal_gain);
    modport ctrl (output scan, pairing, cal_mode, chsel, step,
                  input tf_sel, pos_input, tag, is_cal, cal_gain);
endinterface
`default_nettype wire

// ---- rtl/acc_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module acc_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] TOP = AW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == TOP) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == TOP) ? '0 : rd_ptr + 1'b1;
        end
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            if (push)
            begin
                mem[wr_ptr] <= in_data;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    full_stall_a:
    assert property (count == FULL |-> !in_ready)
        else $error("buffer offered space while full");
    full_hold_a:
    assert property (count == FULL && !out_ready |=> count == FULL)
        else $error("buffer lost a word while stalled");
endmodule
`default_nettype wire

// ---- rtl/acc_route.sv ----
`timescale 1ns/100ps
`default_nettype none
module acc_route (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Channel selection
    acc_route_if.route rt
);
    logic [2:0] slot, next_slot, n_in, last, pos;
    logic has_cal;

    function automatic logic [1:0] input_tf(input logic [2:0] p);
        case (p)
            3'h0, 3'h1: input_tf = 2'h1;
            3'h2, 3'h3: input_tf = 2'h2;
            default: input_tf = acc_pkg::TF_LAST;
        endcase
    endfunction

    always_comb
    begin
        n_in = rt.pairing ? 3'(acc_pkg::PAIRING_SELECT_PAIRS) : 3'(acc_pkg::PSEUDO_INPUTS);
        has_cal = rt.scan && (rt.cal_mode == acc_pkg::CAL_OFFSET || rt.cal_mode == acc_pkg::CAL_GAIN);
        last = has_cal ? n_in + 3'h1 : n_in - 3'h1;
        next_slot = slot;
        if (!rt.scan || slot > last)
        begin
            next_slot = 3'h0;
        end
        else if (rt.step)
        begin
            next_slot = (slot == last) ? 3'h0 : slot + 3'h1;
        end
        pos = 3'h0;
        rt.is_cal = 1'b0;
        rt.cal_gain = 1'b0;
        rt.tag = slot;
        rt.tf_sel = acc_pkg::TF_LAST;
        if (rt.scan)
        begin
            if (slot < n_in)
            begin
                pos = rt.pairing ? {slot[1:0], 1'b0} : slot;
                rt.tf_sel = input_tf(pos);
            end
            else
            begin
                // Offset slot comes first, gain slot second, same tag
                rt.is_cal = 1'b1;
                rt.cal_gain = (slot != n_in);
                rt.tag = acc_pkg::CAL_TAG;
                rt.tf_sel = acc_pkg::TF_LAST;
            end
        end
        else
        begin
            pos = rt.pairing ? {rt.chsel, 1'b0} : {1'b0, rt.chsel};
            rt.tf_sel = input_tf(pos);
            rt.is_cal = (rt.cal_mode != acc_pkg::CAL_NONE);
            rt.cal_gain = (rt.cal_mode == acc_pkg::CAL_GAIN);
            rt.tag = rt.is_cal ? acc_pkg::CAL_TAG : {1'b0, rt.chsel};
        end
        rt.pos_input = pos;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            slot <= 3'h0;
        end
        else
        begin
            slot <= next_slot;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    input_map_a:
    assert property (!rt.is_cal && rt.pos_input < 3'h2 |-> rt.tf_sel == 2'h1)
        else $error("inputs one and two not on register one");
    scan_cal_map_a:
    assert property (rt.scan && rt.is_cal |-> rt.tf_sel == acc_pkg::TF_LAST)
        else $error("scanned calibration not on register three");
    cal_order_a:
    assert property (rt.scan && rt.is_cal && !rt.cal_gain && rt.step
                     ##1 rt.scan && $stable(rt.cal_mode) && $stable(rt.pairing)
                     |-> rt.is_cal && rt.cal_gain && rt.tag == acc_pkg::CAL_TAG)
        else $error("gain calibration did not follow offset calibration");
endmodule
`default_nettype wire

// ---- verif/acc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module acc_host_model (
    // Serial pins
    output logic sclk,
    input wire logic dout
);
    initial sclk = 1'b0;
    // Clock stands low between frames; each bit is taken just before the fall
    task automatic read_word(output logic [23:0] word);
        word = 24'h000000;
        #3;
        for (int i = 0; i < acc_pkg::SER_BITS; i++)
        begin
            sclk = 1'b1;
            #80;
            word = {word[22:0], dout};
            sclk = 1'b0;
            #80;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/acc_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) num_checks++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
module acc_top_bench;
    logic clk, sys_rst, cfg_wr, cfg_rd, scan_enable, pairing_select, conv_step;
    logic mod_strobe, mod_bit, result_valid, read_req, read_special;
    logic [1:0] cfg_addr, calibration_mode_select, channel_select_code, active_tf;
    logic [7:0] cfg_wdata, cfg_rdata, pga_gain_factor;
    logic [23:0] result_data, word;
    logic sclk, dout, drdy_n, result_ready, mod_filter_reset, osc_enable, full_power_down;
    logic bitstream_output_select, unipolar, offset_dac_sign, offset_dac_connect, active_is_cal;
    logic active_cal_gain, filter_run, common_input_ref;
    logic [2:0] pga_gain_code, offset_dac_mag, active_tag, active_input;
    int error_cnt = 0;
    int num_checks = 0;
    acc_top uut (.clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .scan_enable,
        .pairing_select, .calibration_mode_select, .channel_select_code, .conv_step, .mod_strobe,
        .mod_bit, .result_valid, .result_ready, .result_data, .mod_filter_reset, .filter_run,
        .osc_enable, .full_power_down, .pga_gain_code, .pga_gain_factor, .unipolar, .offset_dac_sign,
        .offset_dac_mag, .offset_dac_connect, .active_tf, .active_tag, .active_input, .active_is_cal,
        .active_cal_gain, .common_input_ref, .read_req, .read_special, .sclk, .dout, .drdy_n,
        .bitstream_output_select);
    acc_host_model host (.sclk, .dout);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk) #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
    endtask
    task automatic rdreg(input logic [1:0] a);
        cfg_addr = a;
        cfg_rd = 1'b1;
        step(1);
        cfg_rd = 1'b0;
        step(1);
    endtask
    // Bounded wait on buffer space or on ready low
    task automatic wait_on(input bit rdy);
        int k;
        for (k = 0; k < 900; k++)
        begin
            if (rdy ? result_ready === 1'b1 : drdy_n === 1'b0)
                break;
            step(1);
        end
        if (k == 900)
        begin
            error_cnt++;
            conclude();
        end
    endtask
    task automatic serial_read(input logic special);
        read_special = special;
        read_req = 1'b1;
        step(1);
        read_req = 1'b0;
        host.read_word(word);
        read_special = 1'b0;
        step(2);
    endtask
    task automatic t_reset();
        `CHK("drdy_n", 1'b1, drdy_n)
        `CHK("gain_factor", 8'h01, pga_gain_factor)
        `CHK("dac_connect", 1'b0, offset_dac_connect)
        serial_read(1'b1);
        `CHK("special_word", 24'h000000, word)
        rdreg(2'h0);
        `CHK("special_rd", 8'h00, cfg_rdata)
    endtask
    task automatic t_active();
        wr(2'h1, 8'hb5);
        `CHK("filter_reset", 1'b1, mod_filter_reset)
        `CHK("drdy_n", 1'b1, drdy_n)
        step(1);
        `CHK("gain_code", 3'h5, pga_gain_code)
        `CHK("gain_factor", 8'h20, pga_gain_factor)
        `CHK("unipolar", 1'b1, unipolar)
        `CHK("dac_mag", 3'h5, offset_dac_mag)
        `CHK("dac_connect", 1'b1, offset_dac_connect)
        wr(2'h1, 8'he8);
        step(1);
        `CHK("gain_factor", 8'h80, pga_gain_factor)
        `CHK("unipolar", 1'b0, unipolar)
        `CHK("dac_sign", 1'b1, offset_dac_sign)
        `CHK("dac_connect", 1'b0, offset_dac_connect)
        wr(2'h2, 8'h31);
        `CHK("filter_reset", 1'b0, mod_filter_reset)
        rdreg(2'h2);
        `CHK("tf2_rd", 8'h31, cfg_rdata)
    endtask
    task automatic t_route();
        pairing_select = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            channel_select_code = 2'(i);
            step(1);
            `CHK("active_tf", 2'(i + 1), active_tf)
            `CHK("active_input", 3'(2 * i), active_input)
            `CHK("common_ref", 1'b0, common_input_ref)
        end
        calibration_mode_select = acc_pkg::CAL_OFFSET;
        channel_select_code = 2'h1;
        step(1);
        `CHK("cal_tf", 2'h2, active_tf)
        `CHK("is_cal", 1'b1, active_is_cal)
        scan_enable = 1'b1;
        calibration_mode_select = acc_pkg::CAL_GAIN;
        step(1);
        conv_step = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            `CHK("scan_tf", (i < 3) ? 2'(i + 1) : acc_pkg::TF_LAST, active_tf)
            `CHK("scan_cal", i > 2, active_is_cal)
            `CHK("scan_gain", i == 4, active_cal_gain)
            `CHK("scan_tag", (i > 2) ? acc_pkg::CAL_TAG : 3'(i), active_tag)
            step(1);
        end
        `CHK("scan_wrap", 2'h1, active_tf)
        {scan_enable, conv_step, pairing_select, calibration_mode_select, channel_select_code} = '0;
        step(1);
        `CHK("common_ref", 1'b1, common_input_ref)
    endtask
    task automatic t_stream();
        wr(2'h0, 8'h20);
        `CHK("stream_sel", 1'b1, bitstream_output_select)
        for (int b = 1; b >= 0; b--)
        begin
            mod_bit = 1'(b);
            mod_strobe = 1'b1;
            step(1);
            mod_strobe = 1'b0;
            `CHK("stream_bit", 1'(b), dout)
            step(1);
            `CHK("strobe_hi", 1'b1, drdy_n)
            step(1);
            `CHK("strobe_lo", 1'b0, drdy_n)
        end
        result_data = 24'ha5c3f0;
        result_valid = 1'b1;
        wait_on(1'b1);
        step(1);
        result_valid = 1'b0;
        wr(2'h0, 8'h00);
        `CHK("stream_sel", 1'b0, bitstream_output_select)
        step(1);
        // Polarity flip on the active register while a result waits in the buffer
        wr(2'h1, 8'hf8);
        `CHK("drdy_n", 1'b1, drdy_n)
        wait_on(1'b0);
        serial_read(1'b0);
        `CHK("result", 24'ha5c3f0, word)
    endtask
    task automatic t_power();
        wr(2'h0, 8'h01);
        `CHK("power_down", 1'b1, full_power_down)
        `CHK("osc_enable", 1'b0, osc_enable)
        `CHK("filter_run", 1'b0, filter_run)
        step(1);
        wr(2'h0, 8'h00);
        rdreg(2'h1);
        `CHK("tf1_rd", 8'hf8, cfg_rdata)
        `CHK("power_down", 1'b1, full_power_down)
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        `CHK("power_down", 1'b0, full_power_down)
    endtask
    initial
    begin
        {cfg_wr, cfg_rd, scan_enable, pairing_select, conv_step, mod_strobe} = '0;
        {mod_bit, result_valid, read_req, read_special, cfg_addr, cfg_wdata} = '0;
        {calibration_mode_select, channel_select_code, result_data} = '0;
        sys_rst = 1'b1;
        step(16);
        sys_rst = 1'b0;
        t_reset();
        t_active();
        t_route();
        t_stream();
        t_power();
        conclude();
    end
endmodule
`default_nettype wire
